// ==== pkg/brcf_pkg.sv ====
// shared constants and types for the binary register command host framer
package brcf_pkg;
	// frame bytes
	localparam logic [7:0] START_BYTE = 8'h01;
	localparam logic [7:0] END_BYTE = 8'h03;
	localparam logic [7:0] ACK_BYTE = 8'h06;
	localparam logic [7:0] NAK_BYTE = 8'h15;
	// opcodes
	localparam logic [4:0] OP_WRITE = 5'h00;
	localparam logic [4:0] OP_READ = 5'h01;
	localparam logic [4:0] OP_READ_RSP = 5'h02;
	localparam logic [4:0] OP_BULK_WRITE = 5'h04;
	localparam logic [4:0] OP_BULK_READ = 5'h05;
	localparam logic [4:0] OP_BULK_RSP = 5'h06;
	// type/format byte field positions
	localparam int OPC_LSB = 3;
	localparam int CHK_BIT = 2;
	// apb register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_WDATA = 8'h0C;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam logic [7:0] REG_RCOUNT = 8'h14;
	// ctrl fields
	localparam int CTRL_GO = 31;
	localparam int CTRL_CHK = 24;
	localparam int CTRL_AL_LSB = 8;
	localparam int CTRL_OP_LSB = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// status fields
	localparam int ST_BUSY = 0;
	localparam int ST_ACK = 1;
	localparam int ST_NAK = 2;
	localparam int ST_TMO = 3;
	localparam int ST_RSP_OK = 4;
	localparam int ST_RSP_BAD = 5;
	// data buffer
	localparam int BUF_DEPTH = 256;
	localparam int BUF_AW = 8;
	// timing
	localparam int CLK_HZ = 125_000_000;
	localparam int RSP_TIMEOUT_MS = 500;
	localparam int RSP_TIMEOUT_CYC = CLK_HZ / 1000 * RSP_TIMEOUT_MS;
	// serial byte streams
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} brcf_byte_t;
	// apb request
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} brcf_apb_req_t;
endpackage : brcf_pkg

// ==== logic/brcf_chk_acc.sv ====
// running xor of frame bytes for the check byte
module brcf_chk_acc (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// control
	input wire logic clear_i,
	input wire logic add_i,
	input wire logic [7:0] byte_i,
	// result
	output logic [7:0] sum_o
);
	typedef struct packed {
		logic [7:0] sum;
	} brcf_chk_state_t;
	brcf_chk_state_t state_reg;
	brcf_chk_state_t state_next;

	always_comb begin
		state_next = state_reg;
		if (clear_i) begin
			state_next.sum = 8'h00;
		end else if (add_i) begin
			state_next.sum = state_reg.sum ^ byte_i;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign sum_o = state_reg.sum;
endmodule // brcf_chk_acc

// ==== logic/brcf_host.sv ====
// host framer: builds command frames, parses ack and read responses
module brcf_host (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// byte stream towards device
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	// byte stream from device (from a uart on this clock)
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	// device reset seen
	input wire logic dev_reset_i
);
	typedef enum logic [3:0] {
		S_IDLE, S_START, S_TYPE, S_LEN, S_ADDR, S_DATA, S_CHK, S_END,
		S_ACK, S_R_START, S_R_TYPE, S_R_LEN, S_R_DATA, S_R_CHK, S_R_END
	} brcf_st_t;
	typedef struct packed {
		brcf_st_t st;
		logic [31:0] ctrl;
		logic [15:0] addr;
		logic [5:0] status;
		logic [7:0] idx;
		logic [7:0] rcount;
		logic [7:0] rlen;
		logic [7:0] wptr;
		logic [7:0] rptr;
		logic flush;
		logic [26:0] tmo;
	} brcf_state_t;
	brcf_state_t s_reg;
	brcf_state_t s_next;
	logic [7:0] wbuf_reg [brcf_pkg::BUF_DEPTH];
	logic [7:0] rbuf_reg [brcf_pkg::BUF_DEPTH];
	logic [7:0] tx_byte;
	logic [7:0] chk_sum;
	logic chk_clear;
	logic chk_add;
	logic [7:0] chk_in;
	logic [4:0] opc;
	logic [1:0] alen;
	logic use_chk;
	logic is_read;
	logic wr_acc;
	logic rd_acc;
	logic tx_fire;

	////////////////////////////////////////////////////////////
	// decode helpers
	// address byte count
	function automatic logic [7:0] addr_bytes(input logic [1:0] code);
		return {5'h00, code, 1'b0} + 8'h02;
	endfunction
	function automatic logic op_reads(input logic [4:0] op);
		return (op == brcf_pkg::OP_READ) || (op == brcf_pkg::OP_BULK_READ);
	endfunction

	assign opc = s_reg.ctrl[brcf_pkg::CTRL_OP_LSB +: 5];
	assign alen = s_reg.ctrl[brcf_pkg::CTRL_AL_LSB +: 2];
	assign use_chk = s_reg.ctrl[brcf_pkg::CTRL_CHK];
	assign is_read = op_reads(opc);
	assign wr_acc = psel_i && penable_i && pwrite_i;
	assign rd_acc = psel_i && penable_i && !pwrite_i;
	assign tx_fire = tx_valid_o && tx_ready_i;

	////////////////////////////////////////////////////////////
	// apb slave, zero wait states
	assign pready_o = 1'b1;
	assign pslverr_o = 1'b0;
	always_comb begin
		case (paddr_i)
			brcf_pkg::REG_CTRL: prdata_o = s_reg.ctrl;
			brcf_pkg::REG_ADDR: prdata_o = {16'h0000, s_reg.addr};
			brcf_pkg::REG_STATUS: prdata_o = {26'h0, s_reg.status};
			brcf_pkg::REG_RDATA: prdata_o = {24'h0, rbuf_reg[s_reg.rptr]};
			brcf_pkg::REG_RCOUNT: prdata_o = {24'h0, s_reg.rcount};
			default: prdata_o = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////
	// outgoing byte select
	always_comb begin
		case (s_reg.st)
			S_START: tx_byte = brcf_pkg::START_BYTE;
			S_TYPE: tx_byte = {opc, use_chk, alen};
			S_LEN: tx_byte = s_reg.ctrl[23:16];
			// address lsb first, upper bytes zero
			S_ADDR: tx_byte = (s_reg.idx == 8'h00) ? s_reg.addr[7:0] :
				(s_reg.idx == 8'h01) ? s_reg.addr[15:8] : 8'h00;
			S_DATA: tx_byte = wbuf_reg[s_reg.idx];
			S_CHK: tx_byte = chk_sum;
			S_END: tx_byte = brcf_pkg::END_BYTE;
			default: tx_byte = 8'h00;
		endcase
	end
	assign tx_valid_o = (s_reg.st >= S_START) && (s_reg.st <= S_END);
	assign tx_data_o = tx_byte;

	// xor covers type, length, address, data of both directions
	assign chk_clear = (s_reg.st == S_IDLE) || (s_reg.st == S_ACK) || (s_reg.st == S_R_START);
	assign chk_add = (tx_fire && (s_reg.st >= S_TYPE) && (s_reg.st <= S_DATA)) ||
		(rx_valid_i && (s_reg.st >= S_R_TYPE) && (s_reg.st <= S_R_DATA));
	assign chk_in = tx_fire ? tx_byte : rx_data_i;

	brcf_chk_acc u_chk (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.clear_i(chk_clear),
		.add_i(chk_add),
		.byte_i(chk_in),
		.sum_o(chk_sum)
	);

	////////////////////////////////////////////////////////////
	// sequencer
	always_comb begin
		s_next = s_reg;
		if (rd_acc && paddr_i == brcf_pkg::REG_RDATA) begin
			s_next.rptr = s_reg.rptr + 8'h01;
		end
		if (wr_acc) begin
			case (paddr_i)
				brcf_pkg::REG_CTRL: s_next.ctrl = {1'b0, pwdata_i[30:0]};
				brcf_pkg::REG_ADDR: s_next.addr = pwdata_i[15:0];
				brcf_pkg::REG_WDATA: s_next.wptr = s_reg.wptr + 8'h01;
				default: s_next.ctrl = s_reg.ctrl;
			endcase
		end
		// device reset sets flush outside idle, but nothing reads the flag; stray byte dropped while idle
		if (dev_reset_i) begin
			s_next.flush = 1'b1;
		end
		if (s_reg.st != S_IDLE && s_reg.st < S_ACK) begin
			s_next.tmo = '0;
		end else if (s_reg.st >= S_ACK) begin
			s_next.tmo = s_reg.tmo + 27'd1;
		end
		case (s_reg.st)
			S_IDLE: begin
				s_next.flush = 1'b0;
				s_next.tmo = '0;
				if (wr_acc && paddr_i == brcf_pkg::REG_CTRL && pwdata_i[brcf_pkg::CTRL_GO]) begin
					s_next.st = S_START;
					s_next.idx = 8'h00;
					s_next.rptr = 8'h00;
					s_next.rcount = 8'h00;
					s_next.status = 6'h01;
				end
			end
			S_START, S_TYPE: if (tx_fire) s_next.st = brcf_st_t'(s_reg.st + 4'd1);
			S_LEN: if (tx_fire) begin
				s_next.st = S_ADDR;
				s_next.idx = 8'h00;
			end
			S_ADDR: if (tx_fire) begin
				s_next.idx = s_reg.idx + 8'h01;
				if (s_reg.idx == addr_bytes(alen) - 8'h01) begin
					s_next.idx = 8'h00;
					// reads carry no data, writes exactly length bytes
					s_next.st = (is_read || s_reg.ctrl[23:16] == 8'h00) ? (use_chk ? S_CHK : S_END) : S_DATA;
				end
			end
			S_DATA: if (tx_fire) begin
				s_next.idx = s_reg.idx + 8'h01;
				if (s_reg.idx == s_reg.ctrl[23:16] - 8'h01) begin
					// one check byte only when flagged
					s_next.st = use_chk ? S_CHK : S_END;
				end
			end
			S_CHK: if (tx_fire) s_next.st = S_END;
			// write buffer refills from slot zero for the next command
			S_END: if (tx_fire) begin
				s_next.st = S_ACK;
				s_next.wptr = 8'h00;
			end
			S_ACK: if (rx_valid_i) begin
				if (rx_data_i == brcf_pkg::ACK_BYTE) begin
					s_next.status[brcf_pkg::ST_ACK] = 1'b1;
					s_next.tmo = '0;
					// length zero expects no frame; missing frame times out
					if (is_read && s_reg.ctrl[23:16] != 8'h00) begin
						s_next.st = S_R_START;
					end else begin
						s_next.st = S_IDLE;
						s_next.status[brcf_pkg::ST_BUSY] = 1'b0;
					end
				end else if (rx_data_i == brcf_pkg::NAK_BYTE) begin
					s_next.status[brcf_pkg::ST_NAK] = 1'b1;
					s_next.status[brcf_pkg::ST_BUSY] = 1'b0;
					s_next.st = S_IDLE;
				end
			end
			S_R_START: if (rx_valid_i && rx_data_i == brcf_pkg::START_BYTE) s_next.st = S_R_TYPE;
			S_R_TYPE: if (rx_valid_i) begin
				if (rx_data_i[7:brcf_pkg::OPC_LSB] == brcf_pkg::OP_READ_RSP ||
					rx_data_i[7:brcf_pkg::OPC_LSB] == brcf_pkg::OP_BULK_RSP) begin
					s_next.st = S_R_LEN;
				end else begin
					s_next.st = S_R_END;
					s_next.status[brcf_pkg::ST_RSP_BAD] = 1'b1;
				end
			end
			S_R_LEN: if (rx_valid_i) begin
				s_next.rlen = rx_data_i;
				s_next.st = (rx_data_i == 8'h00) ? (use_chk ? S_R_CHK : S_R_END) : S_R_DATA;
			end
			S_R_DATA: if (rx_valid_i) begin
				s_next.rcount = s_reg.rcount + 8'h01;
				if (s_reg.rcount == s_reg.rlen - 8'h01) begin
					// answer carries check byte when the command did
					s_next.st = use_chk ? S_R_CHK : S_R_END;
				end
			end
			S_R_CHK: if (rx_valid_i) begin
				if (rx_data_i != chk_sum) s_next.status[brcf_pkg::ST_RSP_BAD] = 1'b1;
				s_next.st = S_R_END;
			end
			S_R_END: if (rx_valid_i) begin
				if (rx_data_i != brcf_pkg::END_BYTE || s_reg.status[brcf_pkg::ST_RSP_BAD]) begin
					s_next.status[brcf_pkg::ST_RSP_BAD] = 1'b1;
				end else begin
					s_next.status[brcf_pkg::ST_RSP_OK] = 1'b1;
				end
				s_next.status[brcf_pkg::ST_BUSY] = 1'b0;
				s_next.st = S_IDLE;
			end
			default: s_next.st = S_IDLE;
		endcase
		// host gives up 500 ms after the end byte or after the ack, even while bytes arrive; device discards partial frames
		if (s_reg.st >= S_ACK && s_reg.tmo >= 27'(brcf_pkg::RSP_TIMEOUT_CYC - 1)) begin
			s_next.st = S_IDLE;
			s_next.status[brcf_pkg::ST_TMO] = 1'b1;
			s_next.status[brcf_pkg::ST_BUSY] = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// byte buffers
	always_ff @(posedge sys_clk_i) begin
		if (wr_acc && paddr_i == brcf_pkg::REG_WDATA) begin
			wbuf_reg[s_reg.wptr] <= pwdata_i[7:0];
		end
		if (s_reg.st == S_R_DATA && rx_valid_i) begin
			rbuf_reg[s_reg.rcount] <= rx_data_i;
		end
	end

	////////////////////////////////////////////////////////////
	// assertions
	property p_start_first;
		@(posedge sys_clk_i) disable iff (rst_i)
		(s_reg.st == S_IDLE) ##1 (s_reg.st == S_START) |-> tx_data_o == brcf_pkg::START_BYTE;
	endproperty
	a_start_first: assert property (p_start_first) else $error("start byte wrong");
	property p_type_fmt;
		@(posedge sys_clk_i) disable iff (rst_i)
		(s_reg.st == S_TYPE) |-> tx_data_o[7:3] == opc && tx_data_o[2] == use_chk;
	endproperty
	a_type_fmt: assert property (p_type_fmt) else $error("type byte wrong");
	property p_end_last;
		@(posedge sys_clk_i) disable iff (rst_i)
		(s_reg.st == S_END && tx_fire) |=> (s_reg.st == S_ACK);
	endproperty
	a_end_last: assert property (p_end_last) else $error("end not followed by ack wait");
	property p_addr_hi_zero;
		@(posedge sys_clk_i) disable iff (rst_i)
		(s_reg.st == S_ADDR && s_reg.idx > 8'h01) |-> tx_data_o == 8'h00;
	endproperty
	a_addr_hi_zero: assert property (p_addr_hi_zero) else $error("address extension nonzero");
	property p_addr_lsb;
		@(posedge sys_clk_i) disable iff (rst_i)
		(s_reg.st == S_ADDR && s_reg.idx == 8'h00) |-> tx_data_o == s_reg.addr[7:0];
	endproperty
	a_addr_lsb: assert property (p_addr_lsb) else $error("address not lsb first");
	property p_read_nodata;
		@(posedge sys_clk_i) disable iff (rst_i)
		is_read |-> s_reg.st != S_DATA;
	endproperty
	a_read_nodata: assert property (p_read_nodata) else $error("read sent data");
	property p_chk_byte;
		@(posedge sys_clk_i) disable iff (rst_i)
		(s_reg.st == S_CHK) |-> use_chk && tx_data_o == chk_sum;
	endproperty
	a_chk_byte: assert property (p_chk_byte) else $error("check byte wrong");
	property p_nak_idle;
		@(posedge sys_clk_i) disable iff (rst_i)
		(s_reg.st == S_ACK && rx_valid_i && rx_data_i == brcf_pkg::NAK_BYTE) |=> s_reg.st == S_IDLE;
	endproperty
	a_nak_idle: assert property (p_nak_idle) else $error("nak not ending command");
	c_write: cover property (@(posedge sys_clk_i) s_reg.st == S_DATA ##1 s_reg.st == S_END);
	c_read: cover property (@(posedge sys_clk_i) s_reg.st == S_R_END ##1 s_reg.status[brcf_pkg::ST_RSP_OK]);
	c_nak: cover property (@(posedge sys_clk_i) s_reg.status[brcf_pkg::ST_NAK]);
endmodule // brcf_host

// ==== dv/brcf_dev_model.sv ====
// behavioural device on the far side of the host framer
module brcf_dev_model (
	// clock
	input wire logic sys_clk_i,
	// bytes from host
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o,
	// bytes to host
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	// scenario knob
	input wire logic force_nak_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [logic [15:0]];
	initial begin
		tx_ready_o = 1'b0;
		rx_valid_o = 1'b0;
		rx_data_o = 8'hA5;
	end
	// random stalls so the host must hold each byte
	task automatic take(output logic [7:0] b);
		logic hit;
		do begin
			@(posedge sys_clk_i);
			hit = tx_valid_i === 1'b1 && tx_ready_o === 1'b1;
			b = tx_data_i;
			tx_ready_o <= $urandom_range(3) != 0;
		end while (!hit);
	endtask
	// idle data shows the inverse, never a stale byte
	task automatic put(input logic [7:0] b);
		repeat (1 + $urandom_range(2)) @(posedge sys_clk_i);
		rx_valid_o <= 1'b1;
		rx_data_o <= b;
		@(posedge sys_clk_i);
		rx_valid_o <= 1'b0;
		rx_data_o <= ~b;
	endtask
	initial begin : parse
		logic [7:0] b, t, l, x, c;
		logic [15:0] a;
		logic ok, wr, rd;
		logic [7:0] d [$];
		forever begin
			do take(b); while (b !== brcf_pkg::START_BYTE);
			take(t);
			take(l);
			wr = t[7:3] == brcf_pkg::OP_WRITE || t[7:3] == brcf_pkg::OP_BULK_WRITE;
			rd = t[7:3] == brcf_pkg::OP_READ || t[7:3] == brcf_pkg::OP_BULK_READ;
			ok = wr || rd;
			x = t ^ l;
			a = 16'h0000;
			d = {};
			for (int i = 0; i < 2 * (t[1:0] + 1); i++) begin
				take(b);
				x ^= b;
				if (i < 2) a[8*i+:8] = b;
				else if (b !== 8'h00) ok = 0;
			end
			if (wr) for (int i = 0; i < l; i++) begin
				take(b);
				x ^= b;
				d.push_back(b);
			end
			if (t[2]) begin
				take(b);
				if (b !== x) ok = 0;
			end
			take(b);
			if (b !== brcf_pkg::END_BYTE) ok = 0;
			ok = ok && !force_nak_i;
			put(ok ? brcf_pkg::ACK_BYTE : brcf_pkg::NAK_BYTE);
			if (ok && l != 0 && wr) foreach (d[i]) mem[16'(a + i)] = d[i];
			if (ok && l != 0 && rd) begin
				c = {t[7:3] == brcf_pkg::OP_READ ? brcf_pkg::OP_READ_RSP : brcf_pkg::OP_BULK_RSP, t[2], 2'b00};
				x = c ^ l;
				put(brcf_pkg::START_BYTE);
				put(c);
				put(l);
				for (int i = 0; i < l; i++) begin
					b = mem[16'(a + i)];
					x ^= b;
					put(b);
				end
				if (t[2]) put(x);
				put(brcf_pkg::END_BYTE);
			end
		end
	end
endmodule // brcf_dev_model

// ==== dv/test_brcf_host.sv ====
// self-checking bench for the host command framer
module test_brcf_host;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [31:0] v; logic [31:0] m;} brcf_exp_t;
	logic sys_clk_i = 0;
	logic rst_i = 1;
	logic psel = 0, penable = 0, pwrite = 0, dev_rst = 0, nak = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd, prdata;
	logic pready, tx_valid, tx_ready, rx_valid;
	logic [7:0] tx_data, rx_data;
	brcf_exp_t q [$];
	brcf_exp_t e;
	int error_cnt = 0, checked = 0;
	always #4 sys_clk_i = ~sys_clk_i;
	brcf_host uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(),
		.tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready), .rx_valid_i(rx_valid),
		.rx_data_i(rx_data), .dev_reset_i(dev_rst));
	brcf_dev_model dev (.sys_clk_i(sys_clk_i), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
		.rx_valid_o(rx_valid), .rx_data_o(rx_data), .force_nak_i(nak));
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic miss(input string s);
		$display("MISMATCH %0t %s", $time, s);
		error_cnt++;
	endtask
	task automatic cmp_reg(input logic [31:0] got, input brcf_exp_t x);
		checked++;
		if ((got & x.m) !== x.v) miss("apb read data");
	endtask
	task automatic cmp_mem(input logic [15:0] a, input logic [7:0] x);
		checked++;
		if (!dev.mem.exists(a) || dev.mem[a] !== x) miss("device register");
	endtask
	// one apb transfer, request held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [31:0] v);
		int n;
		if (!w) q.push_back('{v, m});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_i);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			miss("apb hang");
			test_done();
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 32'h0);
	endtask
	task automatic rdx(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		apb(1'b0, a, 32'h0, m, v);
	endtask
	// check flag in bit 24, length in bits 23-16
	task automatic cmd(input logic [4:0] op, input logic [1:0] al, input logic [7:0] len, input logic [15:0] a,
		input logic chk);
		int n;
		wr(brcf_pkg::REG_ADDR, {16'h0000, a});
		wr(brcf_pkg::REG_CTRL, {1'b1, 6'h00, chk, len, 6'h00, al, 3'h0, op});
		n = 0;
		do begin
			rdx(brcf_pkg::REG_STATUS, 32'h0, 32'h0);
			n++;
		end while (rd[brcf_pkg::ST_BUSY] !== 1'b0 && n < 3000);
		if (n >= 3000) begin
			miss("command hang");
			test_done();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk_i) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (q.size() == 0) miss("unexpected read");
			else begin
				e = q.pop_front();
				if (e.m != 0) cmp_reg(prdata, e);
			end
		end
	end
	initial begin
		repeat (90000) @(posedge sys_clk_i);
		miss("run limit");
		test_done();
	end
	initial begin : main
		logic [15:0] a;
		logic [7:0] d [2];
		logic [7:0] len;
		void'($urandom(65714));
		repeat (16) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		rdx(brcf_pkg::REG_STATUS, 32'hFFFF_FFFF, 32'h0);
		wr(8'h18, 32'hFFFF_FFFF);
		rdx(8'h18, 32'hFFFF_FFFF, 32'h0);
		for (int k = 0; k < 8; k++) begin
			a = 16'($urandom);
			len = (k < 4) ? 8'h01 : 8'h02;
			for (int i = 0; i < len; i++) begin
				d[i] = 8'($urandom);
				wr(brcf_pkg::REG_WDATA, {24'h0, d[i]});
			end
			cmd(k[0] ? brcf_pkg::OP_BULK_WRITE : brcf_pkg::OP_WRITE, 2'(k), len, a, k[1]);
			rdx(brcf_pkg::REG_STATUS, 32'h3F, 32'h02);
			for (int i = 0; i < len; i++) cmp_mem(16'(a + i), d[i]);
			cmd(k[0] ? brcf_pkg::OP_BULK_READ : brcf_pkg::OP_READ, 2'(k), len, a, k[1]);
			rdx(brcf_pkg::REG_STATUS, 32'h3F, 32'h12);
			for (int i = 0; i < len; i++) rdx(brcf_pkg::REG_RDATA, 32'hFF, {24'h0, d[i]});
		end
		cmd(brcf_pkg::OP_READ, 2'b01, 8'h00, a, 1'b1);
		rdx(brcf_pkg::REG_STATUS, 32'h3F, 32'h02);
		nak <= 1'b1;
		wr(brcf_pkg::REG_WDATA, {24'h0, ~d[0]});
		cmd(brcf_pkg::OP_WRITE, 2'b00, 8'h01, a, 1'b0);
		rdx(brcf_pkg::REG_STATUS, 32'h3F, 32'h04);
		cmp_mem(a, d[0]);
		nak <= 1'b0;
		dev_rst <= 1'b1;
		@(posedge sys_clk_i);
		dev_rst <= 1'b0;
		dev.put(8'($urandom));
		cmd(brcf_pkg::OP_READ, 2'b11, 8'h01, a, 1'b1);
		rdx(brcf_pkg::REG_STATUS, 32'h3F, 32'h12);
		rdx(brcf_pkg::REG_RDATA, 32'hFF, {24'h0, d[0]});
		test_done();
	end
endmodule // test_brcf_host
